/* File: hdl/pic_mode_select.sv */
// Per-controller detection mode selection between global and per-channel settings.
// Assumes register values are stable flops from the register file.
`timescale 1ns/1ns
`include "pic_trig_consts.svh"
module pic_mode_select
(
   input wire logic i_global_en,
   input wire logic i_level_trig,
   input wire logic i_single,
   input wire logic i_is_master,
   input wire logic [7:0] i_chan_mode,
   output pic_trig_pkg::chan_mode_t o_mode
);
   logic [7:0] cascade_mask;

   // Cascade inputs only on master when neither single nor global mode
   assign cascade_mask = (i_is_master && !i_global_en && !i_single) ?
      8'((1 << `CASCADE_CHAN_A) | (1 << `CASCADE_CHAN_B)) : 8'h00;

   // Global bit picks one mode for all; else per-channel bits
   assign o_mode.level_sel = i_global_en ? {8{i_level_trig}} : (i_chan_mode & ~cascade_mask);
   assign o_mode.cascade = cascade_mask;
endmodule

/* File: hdl/pic_req_detect.sv */
// Eight-channel request detector, edge or level per channel.
// Assumes request inputs are synchronous to the clock.
`timescale 1ns/1ns
module pic_req_detect
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_req,
   input wire logic [7:0] i_level_sel,
   input wire logic [7:0] i_ack,
   output logic [7:0] o_pending
);
   logic [7:0] prev_q;
   logic [7:0] edge_q;
   logic [7:0] edge_d;
   logic [7:0] rise;

   assign rise = i_req & ~prev_q;
   // Edge seen wins over an acknowledge in the same cycle
   assign edge_d = rise | (edge_q & ~i_ack);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_q <= 8'h00;
         edge_q <= 8'h00;
      end
      else
      begin
         prev_q <= i_req;
         edge_q <= edge_d & ~i_level_sel;
      end
   end

   // Level channels follow input; edge channels hold a latched request
   assign o_pending = (i_level_sel & i_req) | (~i_level_sel & edge_q);
endmodule

/* File: hdl/pic_trig_consts.svh */
// Register map, field positions and reset values of the trigger mode select block.
// Assumes inclusion by bare name from design files.
`ifndef PIC_TRIG_CONSTS_SVH
`define PIC_TRIG_CONSTS_SVH

// Printed offsets are not word multiples: these are register indices
`define IDX_GLOBAL_CONTROL 12'hD00
`define IDX_MASTER_MODE 12'hD02
`define IDX_SLAVE1_MODE 12'hD03
`define IDX_INIT_WORDS 12'hD05
`define IDX_CASCADE_CFG 12'hD06
`define IDX_STATUS 12'hD07

// Field positions
`define GC_MASTER_GLOBAL_BIT 0
`define GC_SLAVE1_GLOBAL_BIT 1
`define GC_SLAVE2_GLOBAL_BIT 2
`define IW_MASTER_ICW1_LEVEL_TRIGGER_BIT 0
`define IW_MASTER_SINGLE_BIT 1
`define IW_SLAVE1_ICW1_LEVEL_TRIGGER_BIT 2
`define CC_INPUT2_BIT 2
`define CC_INPUT5_BIT 5

// Reset values
`define GLOBAL_CONTROL_RST 8'h07
`define MODE_REG_RST 8'h00
`define INIT_WORDS_RST 8'h00
`define CASCADE_CFG_RST 8'h00

`define CASCADE_CHAN_A 2
`define CASCADE_CHAN_B 5

`endif

/* File: hdl/pic_trig_pkg.sv */
// Types of the trigger mode select block.
// Assumes pic_trig_consts.svh holds all numbers.
package pic_trig_pkg;
   typedef struct packed
   {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed
   {
      logic [7:0] level_sel;
      logic [7:0] cascade;
   } chan_mode_t;

   typedef enum logic [1:0] {APB_IDLE, APB_ACCESS} apb_state_t;
endpackage

/* File: hdl/pic_trigger_mode_select.sv */
// Trigger mode select for master and first-slave interrupt controllers, APB register file.
// Assumes an APB master on I_CLK; request lines synchronous to I_CLK.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "pic_trig_consts.svh"

// What this block does
// - Slave1 global on: all channels follow level bit
// - Slave1 global off: per-channel register bits apply
// - Master global on: all channels follow level bit
// - Master global off: per-channel register bits apply
// - Master register bit n: 0 edge, 1 level
// - Slave1 register bit n: 0 edge, 1 level
// - Single mode: channel 5 uses its bit
// - Cascade mode: channel 5 is second-slave input
// - Single mode: channel 2 uses its bit
// - Cascade mode: channel 2 is first-slave input
// - PC mode: second slave bypassed, level13 to ch5
// - All global enables set after reset
module pic_trigger_mode_select
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic [31:0] I_PADDR,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [7:0] I_MASTER_REQ,
   input wire logic [7:0] I_SLAVE1_REQ,
   input wire logic [7:0] I_SLAVE2_REQ,
   input wire logic I_LEVEL13_REQ,
   input wire logic [7:0] I_MASTER_ACK,
   input wire logic [7:0] I_SLAVE1_ACK,
   output logic [7:0] O_MASTER_LEVEL_SEL,
   output logic [7:0] O_SLAVE1_LEVEL_SEL,
   output logic O_SLAVE2_GLOBAL_MODE_EN,
   output logic [7:0] O_MASTER_PENDING,
   output logic [7:0] O_SLAVE1_PENDING
);
   pic_trig_pkg::apb_req_t apb;
   pic_trig_pkg::chan_mode_t master_mode;
   pic_trig_pkg::chan_mode_t slave1_mode;
   logic [7:0] global_ctrl_q;
   logic [7:0] master_chan_mode_q;
   logic [7:0] slave1_chan_mode_q;
   logic [7:0] init_words_q;
   logic [7:0] cascade_cfg_q;
   logic [7:0] master_req_mux;
   logic [7:0] slave1_pending;
   logic [7:0] wr_byte;
   logic [31:0] rd_data_d;
   logic [31:0] rd_data_q;
   logic addr_ok;
   logic access;
   logic wr_en;
   logic pc_compat;
   logic master_global_mode_en;
   logic slave1_global_mode_en;
   logic icw1_level_trigger_m;
   logic icw1_level_trigger_s1;
   logic icw1_single_mode;
   logic cascade_on_input2;
   logic cascade_on_input5;
   logic chan2_trigger_sel;
   logic chan5_trigger_sel;

   // Word index from byte address; register index is a 12-bit printed offset
   function automatic logic is_reg(input logic [31:0] addr, input logic [11:0] idx);
      is_reg = (addr[1:0] == 2'h0) && (addr[31:2] == {18'h00000, idx});
   endfunction

   assign apb = '{paddr: I_PADDR, psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE, pwdata: I_PWDATA};
   assign access = apb.psel && apb.penable;
   assign wr_byte = apb.pwdata[7:0];
   assign addr_ok = is_reg(apb.paddr, `IDX_GLOBAL_CONTROL) || is_reg(apb.paddr, `IDX_MASTER_MODE) ||
      is_reg(apb.paddr, `IDX_SLAVE1_MODE) || is_reg(apb.paddr, `IDX_INIT_WORDS) ||
      is_reg(apb.paddr, `IDX_CASCADE_CFG) || is_reg(apb.paddr, `IDX_STATUS);
   assign wr_en = access && apb.pwrite && addr_ok;

   // Zero-wait slave; unmapped addresses answer with an error
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = access && !addr_ok;

   assign master_global_mode_en = global_ctrl_q[`GC_MASTER_GLOBAL_BIT];
   assign slave1_global_mode_en = global_ctrl_q[`GC_SLAVE1_GLOBAL_BIT];
   assign icw1_level_trigger_m = init_words_q[`IW_MASTER_ICW1_LEVEL_TRIGGER_BIT];
   assign icw1_single_mode = init_words_q[`IW_MASTER_SINGLE_BIT];
   assign icw1_level_trigger_s1 = init_words_q[`IW_SLAVE1_ICW1_LEVEL_TRIGGER_BIT];
   assign cascade_on_input2 = cascade_cfg_q[`CC_INPUT2_BIT];
   assign cascade_on_input5 = cascade_cfg_q[`CC_INPUT5_BIT];
   assign chan2_trigger_sel = master_chan_mode_q[`CASCADE_CHAN_A];
   assign chan5_trigger_sel = master_chan_mode_q[`CASCADE_CHAN_B];
   assign pc_compat = master_global_mode_en && slave1_global_mode_en && cascade_on_input2 && !cascade_on_input5;

   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         global_ctrl_q <= `GLOBAL_CONTROL_RST;
         master_chan_mode_q <= `MODE_REG_RST;
         slave1_chan_mode_q <= `MODE_REG_RST;
         init_words_q <= `INIT_WORDS_RST;
         cascade_cfg_q <= `CASCADE_CFG_RST;
      end
      else if (wr_en)
      begin
         if (is_reg(apb.paddr, `IDX_GLOBAL_CONTROL))
            global_ctrl_q <= wr_byte & 8'h07;
         if (is_reg(apb.paddr, `IDX_MASTER_MODE))
            master_chan_mode_q <= wr_byte;
         if (is_reg(apb.paddr, `IDX_SLAVE1_MODE))
            slave1_chan_mode_q <= wr_byte;
         if (is_reg(apb.paddr, `IDX_INIT_WORDS))
            init_words_q <= wr_byte & 8'h07;
         if (is_reg(apb.paddr, `IDX_CASCADE_CFG))
            cascade_cfg_q <= wr_byte;
      end
   end

   pic_mode_select u_master_sel
   (
      .i_global_en(master_global_mode_en),
      .i_level_trig(icw1_level_trigger_m),
      .i_single(icw1_single_mode),
      .i_is_master(1'b1),
      .i_chan_mode(master_chan_mode_q),
      .o_mode(master_mode)
   );

   pic_mode_select u_slave1_sel
   (
      .i_global_en(slave1_global_mode_en),
      .i_level_trig(icw1_level_trigger_s1),
      .i_single(1'b1),
      .i_is_master(1'b0),
      .i_chan_mode(slave1_chan_mode_q),
      .o_mode(slave1_mode)
   );

   // Channel 2 carries first-slave cascade; channel 5 second slave or level13 in PC mode
   assign master_req_mux[1:0] = I_MASTER_REQ[1:0];
   assign master_req_mux[2] = master_mode.cascade[2] ? |slave1_pending : I_MASTER_REQ[2];
   assign master_req_mux[4:3] = I_MASTER_REQ[4:3];
   assign master_req_mux[5] = pc_compat ? I_LEVEL13_REQ :
      (master_mode.cascade[5] ? |I_SLAVE2_REQ : I_MASTER_REQ[5]);
   assign master_req_mux[7:6] = I_MASTER_REQ[7:6];

   pic_req_detect u_master_det
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_req(master_req_mux),
      .i_level_sel(master_mode.level_sel),
      .i_ack(I_MASTER_ACK),
      .o_pending(O_MASTER_PENDING)
   );

   pic_req_detect u_slave1_det
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_req(I_SLAVE1_REQ),
      .i_level_sel(slave1_mode.level_sel),
      .i_ack(I_SLAVE1_ACK),
      .o_pending(slave1_pending)
   );
   assign O_SLAVE1_PENDING = slave1_pending;

   // Read mux; status word shows effective modes and PC mode
   always_comb
   begin
      rd_data_d = 32'h00000000;
      if (is_reg(apb.paddr, `IDX_GLOBAL_CONTROL))
         rd_data_d = {24'h000000, global_ctrl_q};
      else if (is_reg(apb.paddr, `IDX_MASTER_MODE))
         rd_data_d = {24'h000000, master_chan_mode_q};
      else if (is_reg(apb.paddr, `IDX_SLAVE1_MODE))
         rd_data_d = {24'h000000, slave1_chan_mode_q};
      else if (is_reg(apb.paddr, `IDX_INIT_WORDS))
         rd_data_d = {24'h000000, init_words_q};
      else if (is_reg(apb.paddr, `IDX_CASCADE_CFG))
         rd_data_d = {24'h000000, cascade_cfg_q};
      else if (is_reg(apb.paddr, `IDX_STATUS))
         rd_data_d = {15'h0000, pc_compat, slave1_mode.level_sel, master_mode.level_sel};
   end

   // Read data is registered in setup so it is valid through the access phase
   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         rd_data_q <= 32'h00000000;
      else if (apb.psel && !apb.penable && !apb.pwrite)
         rd_data_q <= rd_data_d;
   end
   assign O_PRDATA = rd_data_q;

   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         O_MASTER_LEVEL_SEL <= 8'h00;
         O_SLAVE1_LEVEL_SEL <= 8'h00;
         O_SLAVE2_GLOBAL_MODE_EN <= 1'b1;
      end
      else
      begin
         O_MASTER_LEVEL_SEL <= master_mode.level_sel;
         O_SLAVE1_LEVEL_SEL <= slave1_mode.level_sel;
         O_SLAVE2_GLOBAL_MODE_EN <= global_ctrl_q[`GC_SLAVE2_GLOBAL_BIT];
      end
   end

   property p_master_global;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      master_global_mode_en |=> O_MASTER_LEVEL_SEL == {8{$past(icw1_level_trigger_m)}};
   endproperty
   a_master_global: assert property (p_master_global) else $error("master global mode wrong");

   property p_slave1_global;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      slave1_global_mode_en |=> O_SLAVE1_LEVEL_SEL == {8{$past(icw1_level_trigger_s1)}};
   endproperty
   a_slave1_global: assert property (p_slave1_global) else $error("slave1 global mode wrong");

   property p_slave1_chan;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      !slave1_global_mode_en |=> O_SLAVE1_LEVEL_SEL == $past(slave1_chan_mode_q);
   endproperty
   a_slave1_chan: assert property (p_slave1_chan) else $error("slave1 channel mode wrong");

   property p_master_chan;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (!master_global_mode_en && icw1_single_mode) |=> O_MASTER_LEVEL_SEL == $past(master_chan_mode_q);
   endproperty
   a_master_chan: assert property (p_master_chan) else $error("master channel mode wrong");

   property p_single_ch25;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (!master_global_mode_en && icw1_single_mode && chan5_trigger_sel && chan2_trigger_sel)
         |=> O_MASTER_LEVEL_SEL[5] && O_MASTER_LEVEL_SEL[2];
   endproperty
   a_single_ch25: assert property (p_single_ch25) else $error("single mode ch2/ch5 wrong");

   property p_cascade;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (!master_global_mode_en && !icw1_single_mode) |=> !O_MASTER_LEVEL_SEL[5] && !O_MASTER_LEVEL_SEL[2];
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade channels not ignored");

   property p_cascade2;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (!master_global_mode_en && !icw1_single_mode) |-> master_req_mux[2] == |slave1_pending;
   endproperty
   a_cascade2: assert property (p_cascade2) else $error("channel 2 not cascade input");

   property p_pc_mode;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (pc_compat && icw1_level_trigger_m && I_LEVEL13_REQ) |-> O_MASTER_PENDING[5];
   endproperty
   a_pc_mode: assert property (p_pc_mode) else $error("level13 not on channel 5");

   property p_write_mode;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      (wr_en && is_reg(apb.paddr, `IDX_MASTER_MODE)) |=> master_chan_mode_q == $past(wr_byte);
   endproperty
   a_write_mode: assert property (p_write_mode) else $error("mode register not written");

   c_pc_compat: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) pc_compat && I_LEVEL13_REQ);
   c_cascade: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) master_mode.cascade[2] && |slave1_pending);
   c_per_chan: cover property (@(posedge I_CLK) disable iff (I_SYS_RST)
      !master_global_mode_en && icw1_single_mode && |master_chan_mode_q);
endmodule

/* File: tb/pic_trigger_mode_select_test.sv */
// Self-checking bench for the trigger mode select block: register map, mode selection, request detection.
// Assumes the design answers APB with zero wait states and reports effective modes one cycle after a write.
`timescale 1ns/1ns
`include "pic_trig_consts.svh"
module pic_trigger_mode_select_test;
   localparam logic [31:0] A_CTRL = {18'h0, `IDX_GLOBAL_CONTROL, 2'b00};
   localparam logic [31:0] A_MM = {18'h0, `IDX_MASTER_MODE, 2'b00};
   localparam logic [31:0] A_SM = {18'h0, `IDX_SLAVE1_MODE, 2'b00};
   localparam logic [31:0] A_INIT = {18'h0, `IDX_INIT_WORDS, 2'b00};
   localparam logic [31:0] A_CASC = {18'h0, `IDX_CASCADE_CFG, 2'b00};
   localparam logic [31:0] A_STAT = {18'h0, `IDX_STATUS, 2'b00};
   typedef struct packed {logic [7:0] ctrl; logic [7:0] init; logic [7:0] mm; logic [7:0] sm;
      logic [7:0] em; logic [7:0] es;} row_t;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [31:0] paddr = 32'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] mreq = 8'h00;
   logic [7:0] sreq = 8'h00;
   logic [7:0] s2req = 8'h00;
   logic l13 = 1'b0;
   logic [7:0] mack = 8'h00;
   logic [7:0] sack = 8'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] m_sel;
   logic [7:0] s_sel;
   logic s2_en;
   logic [7:0] m_pend;
   logic [7:0] s_pend;
   int n_mismatch = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;
   row_t rows [0:8];

   always #50 i_clk = ~i_clk;

   pic_trigger_mode_select pic_trigger_mode_select_inst
   (
      .I_CLK(i_clk), .I_SYS_RST(i_sys_rst), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_MASTER_REQ(mreq), .I_SLAVE1_REQ(sreq), .I_SLAVE2_REQ(s2req), .I_LEVEL13_REQ(l13),
      .I_MASTER_ACK(mack), .I_SLAVE1_ACK(sack), .O_MASTER_LEVEL_SEL(m_sel), .O_SLAVE1_LEVEL_SEL(s_sel),
      .O_SLAVE2_GLOBAL_MODE_EN(s2_en), .O_MASTER_PENDING(m_pend), .O_SLAVE1_PENDING(s_pend)
   );

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask

   task automatic tally_and_finish;
   begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask

   // One APB transfer; starts after an edge and releases only after pready is seen
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r,
      output logic e);
   begin
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      // Wait as long as the slave needs; only the watchdog ends a hang
      do
         @(posedge i_clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
   begin
      apb(1'b1, a, d, rd, er);
      check("write error flag", {31'h0, er}, 32'h0);
   end
   endtask

   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
   begin
      apb(1'b0, a, 32'h0, rd, er);
      check(name, rd, exp);
   end
   endtask

   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      tally_and_finish;
   end

   initial
   begin
      // ctrl, init words, master mode, slave1 mode, expected master sel, expected slave1 sel
      rows[0] = '{8'h07, 8'h00, 8'hA5, 8'h3C, 8'h00, 8'h00};
      rows[1] = '{8'h07, 8'h05, 8'h00, 8'h00, 8'hFF, 8'hFF};
      rows[2] = '{8'h07, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h00};
      rows[3] = '{8'h04, 8'h07, 8'hA5, 8'h3C, 8'hA5, 8'h3C};
      rows[4] = '{8'h04, 8'h05, 8'hA5, 8'h3C, 8'h81, 8'h3C};
      rows[5] = '{8'h04, 8'h02, 8'h5A, 8'hC3, 8'h5A, 8'hC3};
      rows[6] = '{8'h05, 8'h04, 8'hFF, 8'h0F, 8'h00, 8'h0F};
      rows[7] = '{8'h06, 8'h04, 8'hFF, 8'h0F, 8'hDB, 8'hFF};
      rows[8] = '{8'h04, 8'h00, 8'hFF, 8'hFF, 8'hDB, 8'hFF};
      repeat (20) @(posedge i_clk);
      check("slave2 global in reset", {31'h0, s2_en}, 32'h1);
      i_sys_rst <= 1'b0;
      rd_chk("control reset", A_CTRL, {24'h0, `GLOBAL_CONTROL_RST});
      rd_chk("master mode reset", A_MM, 32'h0);
      rd_chk("slave1 mode reset", A_SM, 32'h0);
      rd_chk("init reset", A_INIT, 32'h0);
      rd_chk("cascade reset", A_CASC, 32'h0);
      check("master sel after reset", {24'h0, m_sel}, 32'h0);
      wr(A_MM, 32'hFFFF_FF00);
      rd_chk("upper bits dropped", A_MM, 32'h0);
      apb(1'b1, A_CTRL + 32'h4, 32'hFF, rd, er);
      check("unmapped error", {31'h0, er}, 32'h1);
      apb(1'b0, A_MM + 32'h1, 32'h0, rd, er);
      check("misaligned error", {31'h0, er}, 32'h1);
      foreach (rows[i])
      begin
         wr(A_CTRL, {24'h0, rows[i].ctrl});
         wr(A_INIT, {24'h0, rows[i].init});
         wr(A_MM, {24'h0, rows[i].mm});
         wr(A_SM, {24'h0, rows[i].sm});
         repeat (3) @(posedge i_clk);
         check("master level sel", {24'h0, m_sel}, {24'h0, rows[i].em});
         check("slave1 level sel", {24'h0, s_sel}, {24'h0, rows[i].es});
         check("slave2 enable", {31'h0, s2_en}, {31'h0, rows[i].ctrl[`GC_SLAVE2_GLOBAL_BIT]});
         rd_chk("status", A_STAT, {16'h0, rows[i].es, rows[i].em});
      end
      // Master edge-mode channel 0, slave1 level-mode channel 3
      wr(A_CTRL, 32'h5);
      wr(A_INIT, 32'h0);
      wr(A_SM, 32'h08);
      repeat (3) @(posedge i_clk);
      mreq <= 8'h01;
      sreq <= 8'h08;
      @(posedge i_clk);
      check("level pending same cycle", {24'h0, s_pend}, 32'h08);
      sreq <= 8'h00;
      @(posedge i_clk);
      check("edge pending latched", {24'h0, m_pend}, 32'h01);
      check("level pending follows", {24'h0, s_pend}, 32'h0);
      mack <= 8'h01;
      @(posedge i_clk);
      mack <= 8'h00;
      @(posedge i_clk);
      check("edge pending cleared", {24'h0, m_pend}, 32'h0);
      mreq <= 8'h00;
      // Cascade mode: channel 2 takes first-slave pending, channel 5 second-slave requests
      wr(A_CTRL, 32'h4);
      wr(A_INIT, 32'h0);
      repeat (3) @(posedge i_clk);
      sreq <= 8'h08;
      s2req <= 8'h01;
      @(posedge i_clk);
      @(posedge i_clk);
      check("cascade inputs latched", {24'h0, m_pend}, 32'h24);
      sreq <= 8'h00;
      s2req <= 8'h00;
      mack <= 8'h24;
      @(posedge i_clk);
      mack <= 8'h00;
      @(posedge i_clk);
      check("cascade inputs cleared", {24'h0, m_pend}, 32'h0);
      // PC-compatible setup with master level trigger: channel 5 follows level 13 source
      wr(A_CTRL, 32'h7);
      wr(A_INIT, 32'h1);
      wr(A_CASC, 32'h04);
      repeat (3) @(posedge i_clk);
      rd_chk("pc compatible flag", A_STAT, 32'h0001_00FF);
      s2req <= 8'hFF;
      @(posedge i_clk);
      check("slave2 bypassed", {31'h0, m_pend[5]}, 32'h0);
      l13 <= 1'b1;
      @(posedge i_clk);
      check("level 13 to channel 5", {31'h0, m_pend[5]}, 32'h1);
      l13 <= 1'b0;
      s2req <= 8'h00;
      @(posedge i_clk);
      // Mid-run reset brings every global enable back on
      i_sys_rst <= 1'b1;
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd_chk("control after mid reset", A_CTRL, {24'h0, `GLOBAL_CONTROL_RST});
      rd_chk("status after mid reset", A_STAT, 32'h0);
      check("slave2 global after mid reset", {31'h0, s2_en}, 32'h1);
      tally_and_finish;
   end
endmodule
